/* File: design/fcc_pkg.sv */
// constants shared by the switch controller and its input synchroniser
// assumes one 40 MHz clock; all times are turned into whole clock cycles here
package fcc_pkg;
  localparam int FREQ_KHZ = 40000; // core clock rate in kHz
  localparam int CW = 22; // width of the shared state counter
  localparam int LIM_W = 16; // width of the over-voltage time limit, in cycles

  // leading-edge blanking after turn-on, least time so rounded up
  localparam int SENSE_BLANKING_NS = 500;
  localparam int LEB_CYC = (SENSE_BLANKING_NS * FREQ_KHZ + 999999) / 1000000;
  // highest switching frequency gives the least period, rounded up
  localparam int FMAX_KHZ = 70;
  localparam int MIN_PER_CYC = (FREQ_KHZ + FMAX_KHZ - 1) / FMAX_KHZ;
  // on-time is capped at a share of the least period, rounded down
  localparam int DUTY_MAX_PCT = 42;
  localparam int ON_MAX_CYC = MIN_PER_CYC * DUTY_MAX_PCT / 100;
  // longest demagnetization interval, longest time so rounded down
  localparam int TOFF_MAX_US = 220;
  localparam int TOFF_MAX_CYC = TOFF_MAX_US * FREQ_KHZ / 1000;
  // low fixed frequency while the output is shorted, in tenths of a kHz
  localparam int SHORT_FREQ_X10_KHZ = 45;
  localparam int SHORT_PER_CYC = FREQ_KHZ * 10 / SHORT_FREQ_X10_KHZ;
  // open-load restart delay
  localparam int OVP_RST_MS = 60;
  localparam int OVP_RST_CYC = OVP_RST_MS * FREQ_KHZ;
  // default over-voltage demagnetization limit with the setting pin open
  localparam int OVP_DEF_NS = 4500;
  localparam int OVP_DEF_CYC = OVP_DEF_NS * FREQ_KHZ / 1000000;
  localparam int DERATE_W = 4; // width of the thermal derating level

  // one bit changes along idle -> wait and on -> demag -> wait; wait -> on flips two bits
  typedef enum logic [2:0] {
    FCC_IDLE  = 3'h0,
    FCC_ON    = 3'h1,
    FCC_DEMAG = 3'h3,
    FCC_WAIT  = 3'h2,
    FCC_HOLD  = 3'h6
  } fcc_state_e;
endpackage : fcc_pkg

/* File: design/fcc_sense_if.sv */
// synchronised sense and supply levels passed from the synchroniser to the controller
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface fcc_sense_if;
  import fcc_pkg::*;
  logic sup; // internal supply above start threshold
  logic cs_trip; // peak-current comparator tripped
  logic demag; // secondary still conducting
  logic led_short; // output short detected
  logic t_reg; // junction above regulation threshold
  logic t_shut; // shutdown comparator with its own hysteresis
  logic ovp_open; // setting pin open or above upper range
  logic ovp_dis; // setting resistor in the disable range
  logic [LIM_W-1:0] ovp_lim; // limit from setting resistor, in cycles
  modport src (output sup, cs_trip, demag, led_short, t_reg, t_shut, ovp_open, ovp_dis,
    ovp_lim);
  modport snk (input sup, cs_trip, demag, led_short, t_reg, t_shut, ovp_open, ovp_dis,
    ovp_lim);
endinterface : fcc_sense_if
`default_nettype wire

/* File: design/fcc_sync.sv */
// two-flop synchroniser bank for every analog comparator and setting input
// assumes ovp_lim is quasi-static, so a multi-bit two-flop path is acceptable
`timescale 1ns/1ps
`default_nettype none
module fcc_sync
  import fcc_pkg::*;
(
  input wire logic mclk_in, // core clock
  input wire logic rstn_in, // async reset, active low
  input wire logic [7:0] lvl_in, // raw comparator levels
  input wire logic [LIM_W-1:0] lim_in, // raw over-voltage limit
  fcc_sense_if.src sen // synchronised levels
);
  localparam int N = 8 + LIM_W;
  logic [N-1:0] meta_ff; // first stage, read only by the second
  logic [N-1:0] sync_ff;

  // plain two-stage crossing, reset to all inactive
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= {lim_in, lvl_in};
      sync_ff <= meta_ff;
    end
  end

  // unpack into the named levels
  assign sen.sup = sync_ff[0];
  assign sen.cs_trip = sync_ff[1];
  assign sen.demag = sync_ff[2];
  assign sen.led_short = sync_ff[3];
  assign sen.t_reg = sync_ff[4];
  assign sen.t_shut = sync_ff[5];
  assign sen.ovp_open = sync_ff[6];
  assign sen.ovp_dis = sync_ff[7];
  assign sen.ovp_lim = sync_ff[N-1:8];
endmodule : fcc_sync
`default_nettype wire

/* File: design/fcc_ctrl.sv */
// cycle-by-cycle switch controller for a primary-side regulated flyback led driver
// assumes analog comparators and the setting-resistor measurement drive the inputs
`timescale 1ns/1ps
`default_nettype none
module fcc_ctrl
  import fcc_pkg::*;
#(
  parameter int TOFF_CYC = TOFF_MAX_CYC, // demag cap in cycles
  parameter int SHORT_CYC = SHORT_PER_CYC, // short-mode period in cycles
  parameter int OVP_CYC = OVP_RST_CYC // open-load hold-off in cycles
)
(
  input wire logic mclk_in, // core clock, 40 MHz
  input wire logic rstn_in, // async reset, active low
  input wire logic supply_ok_in, // high_voltage_supply_input above start threshold
  input wire logic cs_trip_in, // peak-current comparator, high at threshold
  input wire logic demag_in, // high while secondary conducts
  input wire logic led_short_in, // output short comparator
  input wire logic temp_reg_in, // above 140 C
  input wire logic temp_shut_in, // above 160 C, drops 25 C lower
  input wire logic ovp_open_in, // setting pin open or above 200k
  input wire logic ovp_dis_in, // setting resistor 25k to 200k
  input wire logic [LIM_W-1:0] ovp_lim_in, // limit in cycles from setting resistor
  output logic gate_out, // power switch gate drive
  output logic ovp_latched_out, // open-load protection active
  output logic therm_shut_out, // thermal shutdown active
  output logic short_mode_out, // low-frequency short mode active
  output logic [DERATE_W-1:0] derate_out // current derating level
);
  fcc_sense_if sen ();
  fcc_state_e st_ff, nxt_st;
  logic [CW-1:0] cnt_ff, nxt_cnt; // cycles spent in the current state
  logic [CW-1:0] per_ff; // cycles since last turn-on, saturating
  logic ovp_ff;
  logic [DERATE_W-1:0] der_ff;
  logic gate_ff;
  logic dmg_q_ff; // last synchronised demag level, idles low like the pin

  localparam logic [CW-1:0] LEB_C = CW'(LEB_CYC);
  localparam logic [CW-1:0] ONMAX_C = CW'(ON_MAX_CYC);
  localparam logic [CW-1:0] MINPER_C = CW'(MIN_PER_CYC);
  localparam logic [CW-1:0] TOFF_C = CW'(TOFF_CYC);
  localparam logic [CW-1:0] SHORT_C = CW'(SHORT_CYC);
  localparam logic [CW-1:0] OVP_C = CW'(OVP_CYC);
  localparam logic [CW-1:0] DEF_C = CW'(OVP_DEF_CYC);
  localparam logic [CW-1:0] PER_SAT = '1;

  // every analog level crosses two flops before use
  fcc_sync u_sync (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .lvl_in({ovp_dis_in, ovp_open_in, temp_shut_in, temp_reg_in, led_short_in,
      demag_in, cs_trip_in, supply_ok_in}),
    .lim_in(ovp_lim_in),
    .sen(sen)
  );

  // decoding of the switching conditions
  wire run_ok = sen.sup && !sen.t_shut;
  wire blank_done = cnt_ff >= LEB_C;
  wire peak_off = blank_done && sen.cs_trip;
  wire duty_off = cnt_ff >= ONMAX_C - CW'(1);
  // end on a seen fall or at the cap: the synchroniser delay must not end the interval at once
  wire demag_end = (dmg_q_ff && !sen.demag) || cnt_ff >= TOFF_C - CW'(1);
  // limit picks default, resistor value or none; the count is in clock cycles
  wire [CW-1:0] ovp_lim = sen.ovp_open ? DEF_C : CW'(sen.ovp_lim);
  wire ovp_hit = !sen.ovp_dis && !sen.ovp_open ? (cnt_ff < ovp_lim) :
    (sen.ovp_open && cnt_ff < ovp_lim);
  wire [CW-1:0] per_min = sen.led_short ? SHORT_C : MINPER_C;
  wire per_ok = per_ff >= per_min - CW'(1);
  wire hold_done = ovp_ff ? (cnt_ff >= OVP_C - CW'(1)) : run_ok;

  // next state; supply loss or overheating drop the gate in any state
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      FCC_IDLE: if (run_ok) nxt_st = FCC_WAIT;
      FCC_ON: if (peak_off || duty_off) nxt_st = FCC_DEMAG;
      FCC_DEMAG: if (demag_end) nxt_st = ovp_hit ? FCC_HOLD : FCC_WAIT;
      FCC_WAIT: if (per_ok) nxt_st = FCC_ON;
      FCC_HOLD: if (hold_done) nxt_st = FCC_IDLE;
      default: nxt_st = FCC_IDLE;
    endcase
    if (!run_ok && st_ff != FCC_HOLD && !(st_ff == FCC_DEMAG && demag_end && ovp_hit))
      nxt_st = sen.sup ? FCC_HOLD : FCC_IDLE;
    nxt_cnt = (nxt_st != st_ff) ? '0 : cnt_ff + CW'(1);
  end

  // state and per-state counter
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_ff <= FCC_IDLE;
      cnt_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  // delayed demag level for the falling-edge detect
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      dmg_q_ff <= 1'b0;
    else
      dmg_q_ff <= sen.demag;
  end

  // period counter restarts at turn-on and saturates while idle
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      per_ff <= PER_SAT;
    else if (nxt_st == FCC_ON && st_ff != FCC_ON)
      per_ff <= '0;
    else if (st_ff == FCC_IDLE || st_ff == FCC_HOLD || per_ff == PER_SAT)
      per_ff <= PER_SAT;
    else
      per_ff <= per_ff + CW'(1);
  end

  // open-load latch, held through the hold-off then released
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      ovp_ff <= 1'b0;
    else if (st_ff == FCC_DEMAG && nxt_st == FCC_HOLD && ovp_hit)
      ovp_ff <= 1'b1;
    else if (st_ff == FCC_HOLD && nxt_st == FCC_IDLE)
      ovp_ff <= 1'b0;
  end

  // derating climbs one step per turn-on while hot, eases back when cool
  // coarse steps trade accuracy for a small counter; the trim is applied externally
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      der_ff <= '0;
    else if (st_ff == FCC_WAIT && nxt_st == FCC_ON)
    begin
      if (sen.t_reg && der_ff != '1)
        der_ff <= der_ff + DERATE_W'(1);
      else if (!sen.t_reg && der_ff != '0)
        der_ff <= der_ff - DERATE_W'(1);
    end
  end

  // gate registered straight from the next state, so it falls with the decision
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      gate_ff <= 1'b0;
    else
      gate_ff <= (nxt_st == FCC_ON);
  end

  assign gate_out = gate_ff;
  assign ovp_latched_out = ovp_ff;
  assign therm_shut_out = sen.t_shut;
  assign short_mode_out = sen.led_short;
  assign derate_out = der_ff;

  property p_supply;
    @(posedge mclk_in) disable iff (!rstn_in) !sen.sup |=> !gate_out;
  endproperty
  a_supply: assert property (p_supply) else $error("gate high without supply");

  property p_peak;
    @(posedge mclk_in) disable iff (!rstn_in)
      st_ff == FCC_ON && blank_done && sen.cs_trip |=> !gate_out;
  endproperty
  a_peak: assert property (p_peak) else $error("gate not off at peak trip");

  property p_blank;
    @(posedge mclk_in) disable iff (!rstn_in)
      $fell(gate_out) && $past(run_ok) |-> $past(cnt_ff) >= LEB_C;
  endproperty
  a_blank: assert property (p_blank) else $error("turn-off inside blanking");

  property p_duty;
    @(posedge mclk_in) disable iff (!rstn_in) st_ff == FCC_ON |-> cnt_ff < ONMAX_C;
  endproperty
  a_duty: assert property (p_duty) else $error("on-time over duty limit");

  property p_fmax;
    @(posedge mclk_in) disable iff (!rstn_in)
      $rose(gate_out) |-> $past(per_ff) >= MINPER_C - CW'(2);
  endproperty
  a_fmax: assert property (p_fmax) else $error("period below max-frequency limit");

  property p_short;
    @(posedge mclk_in) disable iff (!rstn_in)
      $rose(gate_out) && $past(sen.led_short) |-> $past(per_ff) >= SHORT_C - CW'(1);
  endproperty
  a_short: assert property (p_short) else $error("short-mode period too short");

  property p_ovp;
    @(posedge mclk_in) disable iff (!rstn_in) $rose(ovp_ff) |-> !gate_out [*8];
  endproperty
  a_ovp: assert property (p_ovp) else $error("switching during open-load hold");

  property p_toff;
    @(posedge mclk_in) disable iff (!rstn_in) st_ff == FCC_DEMAG |-> cnt_ff < TOFF_C;
  endproperty
  a_toff: assert property (p_toff) else $error("demag interval over cap");

  property p_therm;
    @(posedge mclk_in) disable iff (!rstn_in) sen.t_shut |=> !gate_out;
  endproperty
  a_therm: assert property (p_therm) else $error("gate high in thermal shutdown");
endmodule : fcc_ctrl
`default_nettype wire

/* File: testbench/fcc_stage_model.sv */
// behavioural flyback power stage: sense ramp while on, secondary conduction after
// assumes the gate is registered on the rising clock edge of the core clock
`timescale 1ns/1ps
`default_nettype none
module fcc_stage_model
(
  input wire logic clk_in, // core clock
  input wire logic gate_in, // switch gate from the controller
  input wire logic [15:0] ramp_in, // on cycles until the sense level trips
  input wire logic [15:0] demag_len_in, // off cycles of secondary conduction
  output logic cs_trip_out, // peak-current comparator level
  output logic demag_out // high while the secondary conducts
);
  int on_cnt = 0;
  int off_cnt = 100000;
  logic g;
  // gate read before the edge's updates land; outputs move a little later like the bench
  always @(posedge clk_in)
  begin
    g = gate_in;
    #2;
    on_cnt = g ? on_cnt + 1 : 0;
    off_cnt = g ? 0 : off_cnt + 1;
    // no primary current with the switch off, so the comparator stays low then
    cs_trip_out = g && (on_cnt >= ramp_in);
    demag_out = !g && (off_cnt <= demag_len_in);
  end
  // lines defined from time zero
  initial
  begin
    cs_trip_out = 1'b0;
    demag_out = 1'b0;
  end
endmodule // fcc_stage_model
`default_nettype wire

/* File: testbench/flyback_cc_switch_controller_tb.sv */
// self-checking bench for the flyback switch controller with a power stage model
// assumes shortened counts: demag cap 800, short period 900, open-load hold 300 cycles
`timescale 1ns/1ps
`default_nettype none
module flyback_cc_switch_controller_tb
  import fcc_pkg::*;
;
  localparam int TOFF = 800;
  localparam int SHORT = 900;
  localparam int OVP = 300;
  logic mclk_in = 1'b0, rstn_in = 1'b0, supply_ok = 1'b0, led_short = 1'b0;
  logic temp_reg = 1'b0, temp_shut = 1'b0, ovp_open = 1'b0, ovp_dis = 1'b1;
  logic [LIM_W-1:0] ovp_lim = 16'h0000;
  logic [15:0] ramp = 16'h000a, demag_len = 16'h0014;
  logic cs_trip, demag, gate_out, ovp_latched_out, therm_shut_out, short_mode_out;
  logic [DERATE_W-1:0] derate_out;
  int failures = 0, checked = 0, cyc = 0, n_rise = 0, last_rise = 0, per = 0, on_w = 0;
  int k, g0;
  logic gate_q = 1'b0;

  fcc_ctrl #(.TOFF_CYC(TOFF), .SHORT_CYC(SHORT), .OVP_CYC(OVP)) uut (.mclk_in(mclk_in),
    .rstn_in(rstn_in), .supply_ok_in(supply_ok), .cs_trip_in(cs_trip), .demag_in(demag),
    .led_short_in(led_short), .temp_reg_in(temp_reg), .temp_shut_in(temp_shut),
    .ovp_open_in(ovp_open), .ovp_dis_in(ovp_dis), .ovp_lim_in(ovp_lim), .gate_out(gate_out),
    .ovp_latched_out(ovp_latched_out), .therm_shut_out(therm_shut_out),
    .short_mode_out(short_mode_out), .derate_out(derate_out));
  fcc_stage_model stage (.clk_in(mclk_in), .gate_in(gate_out), .ramp_in(ramp),
    .demag_len_in(demag_len), .cs_trip_out(cs_trip), .demag_out(demag));

  // 40 MHz core clock
  initial
  begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  // gate edge bookkeeping: on-time and turn-on to turn-on period; also the hang limit
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    gate_q <= gate_out;
    if (gate_out === 1'b1 && gate_q === 1'b0)
    begin
      n_rise <= n_rise + 1;
      per <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (gate_out === 1'b0 && gate_q === 1'b1)
      on_w <= cyc - last_rise;
    if (cyc == 90000)
    begin
      failures++;
      final_report();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // a window rather than one figure where synchroniser latency blurs the edge
  task chk_rng(input logic [31:0] v, input int lo, input int hi);
    if (v >= lo && v <= hi)
      chk(v, v);
    else
      chk(v, lo);
  endtask
  task step(input int n);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask
  task wait_rises(input int n);
    int t;
    t = n_rise + n;
    for (int i = 0; i < 20000 && n_rise < t; i++) @(posedge mclk_in);
    #2;
  endtask

  task t_start;
    step(3);
    chk({gate_out, ovp_latched_out, therm_shut_out, short_mode_out, derate_out}, 0);
    step(3);
    rstn_in = 1'b1;
    step(50);
    chk(n_rise, 0);
    supply_ok = 1'b1;
    for (k = 0; k < 20 && gate_out !== 1'b1; k++) step(1);
    chk_rng(k, 3, 6);
    wait_rises(2);
    supply_ok = 1'b0;
    step(6);
    chk(gate_out, 0);
    g0 = n_rise;
    step(700);
    chk(n_rise, g0);
    supply_ok = 1'b1;
  endtask

  task t_trip;
    ramp = 16'h0032;
    wait_rises(3);
    chk_rng(on_w, 50, 55);
    ramp = 16'h0001;
    wait_rises(3);
    chk_rng(on_w, LEB_CYC, LEB_CYC + 5);
    ramp = 16'h07d0;
    wait_rises(3);
    chk_rng(on_w, ON_MAX_CYC - 2, ON_MAX_CYC);
    ramp = 16'h000a;
  endtask

  task t_period;
    wait_rises(3);
    chk_rng(per, MIN_PER_CYC, MIN_PER_CYC + 3);
    demag_len = 16'h02bc;
    wait_rises(3);
    chk_rng(per, 716, 730);
    demag_len = 16'h0bb8;
    wait_rises(3);
    chk_rng(per, TOFF, TOFF + 25);
    demag_len = 16'h0014;
    wait_rises(2);
  endtask

  // the setting pins are set during an on-time, so no demag interval straddles the new setting
  task ovp_case(input logic op, input logic ds, input logic [15:0] lim, input logic [15:0] dm,
    input logic exp);
    int hi;
    demag_len = dm;
    wait_rises(1);
    ovp_open = op;
    ovp_dis = ds;
    ovp_lim = lim;
    for (int i = 0; i < 3000 && ovp_latched_out !== 1'b1; i++) step(1);
    chk(ovp_latched_out, exp);
    ovp_dis = 1'b1;
    ovp_open = 1'b0;
    if (exp)
    begin
      g0 = n_rise;
      for (hi = 0; hi < 5000 && ovp_latched_out === 1'b1; hi++) step(1);
      chk_rng(hi, OVP - 3, OVP + 1);
      chk(n_rise, g0);
      for (hi = 0; hi < 1000 && n_rise == g0; hi++) step(1);
      chk_rng(hi, 1, 700);
    end
    wait_rises(1);
    demag_len = 16'h0014;
  endtask

  task t_ovp;
    ovp_case(1'b0, 1'b0, 16'h0064, 16'h001e, 1'b1);
    ovp_case(1'b0, 1'b0, 16'h0064, 16'h0096, 1'b0);
    ovp_case(1'b1, 1'b0, 16'h0000, 16'h0064, 1'b1);
    ovp_case(1'b1, 1'b0, 16'h0000, 16'h012c, 1'b0);
    ovp_case(1'b0, 1'b1, 16'h0064, 16'h001e, 1'b0);
  endtask

  task t_short;
    led_short = 1'b1;
    wait_rises(3);
    chk(short_mode_out, 1);
    chk_rng(per, SHORT, SHORT + 3);
    led_short = 1'b0;
    wait_rises(2);
  endtask

  task t_therm;
    temp_reg = 1'b1;
    wait_rises(4);
    chk_rng(derate_out, 2, 4);
    temp_reg = 1'b0;
    wait_rises(20);
    chk(derate_out, 0);
    wait_rises(1);
    step(3);
    temp_shut = 1'b1;
    g0 = n_rise;
    for (k = 0; k < 10 && gate_out === 1'b1; k++) step(1);
    chk_rng(k, 2, 4);
    chk(therm_shut_out, 1);
    step(1500);
    chk(n_rise, g0);
    temp_shut = 1'b0;
    for (k = 0; k < 2000 && n_rise == g0; k++) step(1);
    chk_rng(k, 2, 700);
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial
  begin
    t_start();
    t_trip();
    t_period();
    t_ovp();
    t_short();
    t_therm();
    final_report();
  end
endmodule // flyback_cc_switch_controller_tb
`default_nettype wire
